// >>> hw/sgr_glue_regs.sv
// Purpose: Switch submodule glue registers: ident, toggle output, MAC enables
// Assumes: Avalon-MM slave with waitrequest, byte addresses, 32-bit data
// Notes:   Every access answers on the second cycle
//
// The register offsets and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/10ps
`include "sgr_map.svh"
module sgr_glue_regs
    import sgr_pkg::*;
#(
    parameter int          ADDR_W    = 4,
    parameter logic [15:0] IDENT     = 16'h5A5A, // Arbitrary value
    parameter logic [4:0]  RTL_VER   = 5'h00,    // Arbitrary value
    parameter logic [2:0]  MAJ_VER   = 3'h1,     // Arbitrary value
    parameter logic [7:0]  MINOR_VER = 8'h00     // Arbitrary value
) (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              rst_n,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [3:0]        avs_byteenable,
    input  wire logic [31:0]       avs_writedata,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    // Receive clocks and lane status
    input  wire logic [1:0]        recovered_receive_clock,
    input  wire logic [6:0]        lane0_link_status,
    input  wire logic [6:0]        lane1_link_status,
    // Port MAC control register bits
    input  wire logic              port1_mac_ctrl_tengig_en,
    input  wire logic              port1_mac_ctrl_gig_en,
    input  wire logic              port2_mac_ctrl_tengig_en,
    input  wire logic              port2_mac_ctrl_gig_en,
    // MAC enables and modes
    output logic                   port1_tengig_enable,
    output logic                   port1_gig_enable,
    output logic                   port2_tengig_enable,
    output logic                   port2_gig_enable,
    output logic                   port1_tengig_mode,
    output logic                   port2_tengig_mode,
    // Toggle output
    output logic                   sync_toggle_output
);
    if (ADDR_W < 4)
        $error("sgr_glue_regs: ADDR_W must be at least 4");

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    logic [31:0]   count_ff;
    sgr_clk_sel_t  sel_ff;
    logic          ext_en_p2_ff;
    logic          ext_en_p1_ff;
    logic          ext_md_p2_ff;
    logic          ext_md_p1_ff;
    logic          mode_p2_ff;
    logic          mode_p1_ff;
    logic          ack_ff;
    logic [31:0]   id_word;
    logic [31:0]   rd_mux;
    logic          req;
    logic          wr_go;
    logic          hit_id;
    logic          hit_cnt;
    logic          hit_sel;
    logic          hit_ctrl;
    logic [1:0]    rx_clk_sync;
    logic [6:0]    lane0_s;
    logic [6:0]    lane1_s;
    logic          l0_xg_up;
    logic          l1_xg_up;
    logic          l1_g_up;
    logic          nxt_p1_xg;
    logic          nxt_p1_g;
    logic          nxt_p2_xg;
    logic          nxt_p2_g;
    logic          nxt_p1_md;
    logic          nxt_p2_md;

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    sgr_sync #(.W(2)) u_sync_clk (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .async_in (recovered_receive_clock),
        .sync_out (rx_clk_sync)
    );

    sgr_sync #(.W(14)) u_sync_lane (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .async_in ({lane1_link_status, lane0_link_status}),
        .sync_out ({lane1_s, lane0_s})
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode
    assign req      = avs_read || avs_write;
    assign avs_waitrequest = req && !ack_ff;
    assign wr_go    = avs_write && ack_ff;
    assign hit_id   = (avs_address == ADDR_W'(`SGR_OFS_IDVER));
    assign hit_cnt  = (avs_address == ADDR_W'(`SGR_OFS_COUNT));
    assign hit_sel  = (avs_address == ADDR_W'(`SGR_OFS_SEL));
    assign hit_ctrl = (avs_address == ADDR_W'(`SGR_OFS_CTRL));

    assign id_word = ({IDENT, 16'h0000} >> (16 - `SGR_ID_IDENT_LSB))
                   | (32'(RTL_VER) << `SGR_ID_RTL_LSB)
                   | (32'(MAJ_VER) << `SGR_ID_MAJ_LSB)
                   | (32'(MINOR_VER) << `SGR_ID_MIN_LSB);

    // Write-only and reserved control bits read as zero
    assign rd_mux = hit_id   ? id_word :
                    hit_cnt  ? count_ff :
                    hit_sel  ? {30'h0000_0000, sel_ff} :
                    hit_ctrl ? {30'h0000_0000, mode_p2_ff, mode_p1_ff} :
                    32'h0000_0000;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_ff       <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end
        else
        begin
            ack_ff <= req && !ack_ff;
            if (avs_read && !ack_ff)
                avs_readdata <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Count register, byte lanes
    for (genvar b = 0; b < 4; b++)
    begin : g_cnt
        always_ff @(posedge mclk or negedge rst_n)
        begin
            if (!rst_n)
                count_ff[8*b +: 8] <= 8'h00;
            else if (wr_go && hit_cnt && avs_byteenable[b])
                count_ff[8*b +: 8] <= avs_writedata[8*b +: 8];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Select and control registers
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sel_ff       <= SGR_SEL_RX0;
            ext_en_p2_ff <= 1'b0;
            ext_en_p1_ff <= 1'b0;
            ext_md_p2_ff <= 1'b0;
            ext_md_p1_ff <= 1'b0;
            mode_p2_ff   <= 1'b0;
            mode_p1_ff   <= 1'b0;
        end
        else
        begin
            if (wr_go && hit_sel && avs_byteenable[0])
                sel_ff <= sgr_clk_sel_t'(avs_writedata[1:0]);
            if (wr_go && hit_ctrl && avs_byteenable[2])
            begin
                ext_en_p2_ff <= avs_writedata[`SGR_CTRL_EXT_EN_P2];
                ext_en_p1_ff <= avs_writedata[`SGR_CTRL_EXT_EN_P1];
            end
            if (wr_go && hit_ctrl && avs_byteenable[1])
            begin
                ext_md_p2_ff <= avs_writedata[`SGR_CTRL_EXT_MD_P2];
                ext_md_p1_ff <= avs_writedata[`SGR_CTRL_EXT_MD_P1];
            end
            if (wr_go && hit_ctrl && avs_byteenable[0])
            begin
                mode_p2_ff <= avs_writedata[`SGR_CTRL_MODE_P2];
                mode_p1_ff <= avs_writedata[`SGR_CTRL_MODE_P1];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Enable and mode selection
    assign l0_xg_up  = (lane0_s[`SGR_LANE_XG_HI:`SGR_LANE_XG_LO] == `SGR_LANE_UP);
    assign l1_xg_up  = (lane1_s[`SGR_LANE_XG_HI:`SGR_LANE_XG_LO] == `SGR_LANE_UP);
    assign l1_g_up   = (lane1_s[`SGR_LANE_G_HI:`SGR_LANE_G_LO] == `SGR_LANE_UP);
    assign nxt_p2_xg = ext_en_p2_ff ? l1_xg_up : port2_mac_ctrl_tengig_en;
    assign nxt_p2_g  = ext_en_p2_ff ? l1_g_up : port2_mac_ctrl_gig_en;
    assign nxt_p1_xg = ext_en_p1_ff ? l1_xg_up : port1_mac_ctrl_tengig_en;
    assign nxt_p1_g  = ext_en_p1_ff ? l1_g_up : port1_mac_ctrl_gig_en;
    assign nxt_p2_md = ext_md_p2_ff ? l1_xg_up : mode_p2_ff;
    assign nxt_p1_md = ext_md_p1_ff ? l0_xg_up : mode_p1_ff;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            port1_tengig_enable <= 1'b0;
            port1_gig_enable    <= 1'b0;
            port2_tengig_enable <= 1'b0;
            port2_gig_enable    <= 1'b0;
            port1_tengig_mode   <= 1'b0;
            port2_tengig_mode   <= 1'b0;
        end
        else
        begin
            port1_tengig_enable <= nxt_p1_xg;
            port1_gig_enable    <= nxt_p1_g;
            port2_tengig_enable <= nxt_p2_xg;
            port2_gig_enable    <= nxt_p2_g;
            port1_tengig_mode   <= nxt_p1_md;
            port2_tengig_mode   <= nxt_p2_md;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Toggle output generator
    // Receive clocks are sampled into mclk, so settings need no crossing
    sgr_synce_gen u_synce (
        .mclk               (mclk),
        .rst_n              (rst_n),
        .rx_clk_sync        (rx_clk_sync),
        .count_i            (count_ff),
        .sel_i              (sel_ff),
        .sync_toggle_output (sync_toggle_output)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_read_done(logic hit);
        avs_read && hit && !avs_waitrequest;
    endsequence

    sequence s_write_done(logic hit);
        avs_write && hit && !avs_waitrequest;
    endsequence

    a_bus_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest held more than one cycle");
    a_id_read_word: assert property (s_read_done(hit_id) |-> avs_readdata == id_word)
        else $error("ident word read back wrong");
    a_ctrl_reads_zero: assert property (s_read_done(hit_ctrl) |-> avs_readdata[31:2] == 30'h0000_0000)
        else $error("control upper bits not zero");
    a_count_write_lands: assert property (s_write_done(hit_cnt && avs_byteenable == 4'hF)
                                          |=> count_ff == $past(avs_writedata))
        else $error("count write not stored");
    a_mode_write_lands: assert property (s_write_done(hit_ctrl && avs_byteenable[0])
                                         |=> mode_p1_ff == $past(avs_writedata[0]))
        else $error("mode bit write not stored");
    a_sel_write_lands: assert property (s_write_done(hit_sel && avs_byteenable[0])
                                        |=> sel_ff == $past(avs_writedata[1:0]))
        else $error("select write not stored");
    a_ext_en_lands: assert property (s_write_done(hit_ctrl && avs_byteenable[2])
                                     |=> ext_en_p2_ff == $past(avs_writedata[`SGR_CTRL_EXT_EN_P2]))
        else $error("port2 enable source write not stored");
    a_unmapped_reads_zero: assert property (s_read_done(!(hit_id || hit_cnt || hit_sel || hit_ctrl))
                                            |-> avs_readdata == 32'h0000_0000)
        else $error("unmapped address read not zero");

    // Enable and mode sources
    a_port2_lane_en: assert property (ext_en_p2_ff && l1_xg_up && l1_g_up
                                      |=> port2_tengig_enable && port2_gig_enable)
        else $error("port2 enables ignore lane status");
    a_port2_lane_off: assert property (ext_en_p2_ff && !l1_xg_up |=> !port2_tengig_enable)
        else $error("port2 tengig enable without lane status");
    a_port2_mac_en: assert property (!ext_en_p2_ff
                                     |=> port2_tengig_enable == $past(port2_mac_ctrl_tengig_en))
        else $error("port2 enable ignores MAC control");
    a_port2_gig_mac: assert property (!ext_en_p2_ff
                                      |=> port2_gig_enable == $past(port2_mac_ctrl_gig_en))
        else $error("port2 gig enable ignores MAC control");
    a_port1_lane_en: assert property (ext_en_p1_ff && !l1_g_up |=> !port1_gig_enable)
        else $error("port1 gig enable without lane status");
    a_port1_lane_xg: assert property (ext_en_p1_ff |=> port1_tengig_enable == $past(l1_xg_up))
        else $error("port1 tengig enable not from lane1");
    a_port1_mac_en: assert property (!ext_en_p1_ff
                                     |=> port1_tengig_enable == $past(port1_mac_ctrl_tengig_en))
        else $error("port1 enable ignores MAC control");
    a_port1_mode_src: assert property (ext_md_p1_ff |=> port1_tengig_mode == $past(l0_xg_up))
        else $error("port1 mode not from lane0");
    a_port1_mode_bit: assert property (!ext_md_p1_ff |=> port1_tengig_mode == $past(mode_p1_ff))
        else $error("port1 mode not from control bit");
    a_port2_mode_src: assert property (!ext_md_p2_ff |=> port2_tengig_mode == $past(mode_p2_ff))
        else $error("port2 mode not from control bit");
    a_port2_mode_lane: assert property (ext_md_p2_ff |=> port2_tengig_mode == $past(l1_xg_up))
        else $error("port2 mode not from lane1");
endmodule

// >>> hw/sgr_map.svh
// Purpose: Register offsets, field positions and reset values of the glue registers
// Assumes: Byte addresses on a 32-bit Avalon-MM slave
// Notes:   Definitions only
`ifndef SGR_MAP_SVH
`define SGR_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// Register offsets
`define SGR_OFS_IDVER      4'h0
`define SGR_OFS_COUNT      4'h4
`define SGR_OFS_SEL        4'h8
`define SGR_OFS_CTRL       4'hC

////////////////////////////////////////////////////////////////////////////////
// Identification word fields
`define SGR_ID_IDENT_LSB   16
`define SGR_ID_RTL_LSB     11
`define SGR_ID_MAJ_LSB     8
`define SGR_ID_MIN_LSB     0

////////////////////////////////////////////////////////////////////////////////
// Control word fields
`define SGR_CTRL_EXT_EN_P2 17
`define SGR_CTRL_EXT_EN_P1 16
`define SGR_CTRL_EXT_MD_P2 9
`define SGR_CTRL_EXT_MD_P1 8
`define SGR_CTRL_MODE_P2   1
`define SGR_CTRL_MODE_P1   0

////////////////////////////////////////////////////////////////////////////////
// Lane link status fields
`define SGR_LANE_XG_HI     4
`define SGR_LANE_XG_LO     3
`define SGR_LANE_G_HI      6
`define SGR_LANE_G_LO      5
`define SGR_LANE_UP        2'h3
`define SGR_LANE_W         7

////////////////////////////////////////////////////////////////////////////////
// Reset values and counter step
`define SGR_RST_COUNT      32'h0000_0000
`define SGR_RST_SEL        2'h0
`define SGR_RST_CTRL       4'h0
`define SGR_CNT_ONE        32'h0000_0001

`endif

// >>> hw/sgr_pkg.sv
// Purpose: Types shared by the glue register files
// Assumes: Nothing
// Notes:   Constants live in sgr_map.svh
package sgr_pkg;
    typedef enum logic [1:0] {
        SGR_SEL_RX0  = 2'h0,
        SGR_SEL_RX1  = 2'h1,
        SGR_SEL_RSV2 = 2'h2,
        SGR_SEL_RSV3 = 2'h3
    } sgr_clk_sel_t;
endpackage

// >>> hw/sgr_sync.sv
// Purpose: Two-flop synchroniser per bit
// Assumes: Inputs asynchronous to mclk
// Notes:   First stage feeds only the second
`timescale 1ns/10ps
module sgr_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rst_n,
    // Data
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    if (W < 1)
        $error("sgr_sync: W must be at least 1");

    for (genvar i = 0; i < W; i++)
    begin : g_bit
        logic meta_ff;
        always_ff @(posedge mclk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                meta_ff     <= 1'b0;
                sync_out[i] <= 1'b0;
            end
            else
            begin
                meta_ff     <= async_in[i];
                sync_out[i] <= meta_ff;
            end
        end
    end
endmodule

// >>> hw/sgr_synce_gen.sv
// Purpose: Toggle output generator counting edges of the chosen receive clock
// Assumes: Receive clocks already synchronised, slower than half of mclk
// Notes:   Counter restarts from zero on each match
`timescale 1ns/10ps
`include "sgr_map.svh"
module sgr_synce_gen
    import sgr_pkg::*;
(
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rst_n,
    // Receive clocks, synchronised
    input  wire logic [1:0]   rx_clk_sync,
    // Settings
    input  wire logic [31:0]  count_i,
    input  sgr_clk_sel_t      sel_i,
    // Output
    output logic              sync_toggle_output
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    logic [1:0]  prev_ff;
    logic [31:0] cnt_ff;
    logic [31:0] cnt_plus;
    logic [1:0]  rise;
    logic        sel_edge;
    logic        hit;
    logic        cnt_off;

    ////////////////////////////////////////////////////////////////////////////
    // Edge select and match
    assign rise     = rx_clk_sync & ~prev_ff;
    assign sel_edge = (sel_i == SGR_SEL_RX0) ? rise[0] :
                      (sel_i == SGR_SEL_RX1) ? rise[1] : 1'b0;
    assign cnt_plus = cnt_ff + `SGR_CNT_ONE;
    assign cnt_off  = (count_i == `SGR_RST_COUNT);
    assign hit      = sel_edge && (cnt_plus == count_i);

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prev_ff            <= 2'h0;
            cnt_ff             <= `SGR_RST_COUNT;
            sync_toggle_output <= 1'b0;
        end
        else
        begin
            prev_ff <= rx_clk_sync;
            if (cnt_off)
            begin
                cnt_ff             <= `SGR_RST_COUNT;
                sync_toggle_output <= 1'b0;
            end
            else if (hit)
            begin
                cnt_ff             <= `SGR_RST_COUNT;
                sync_toggle_output <= ~sync_toggle_output;
            end
            else if (sel_edge)
                cnt_ff <= cnt_plus;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_sync_held_low: assert property (cnt_off |=> !sync_toggle_output)
        else $error("toggle output not low while count is zero");
    a_sync_toggle_hit: assert property (!cnt_off && hit |=> $changed(sync_toggle_output))
        else $error("toggle output did not invert on match");
    a_sync_no_hit: assert property (!hit && !cnt_off |=> $stable(sync_toggle_output))
        else $error("toggle output moved without a match");
    a_cnt_restart: assert property (!cnt_off && hit |=> cnt_ff == `SGR_RST_COUNT)
        else $error("counter did not restart after match");
    a_sel_reserved: assert property (sel_i[1] && !cnt_off |=> $stable(cnt_ff))
        else $error("counter advanced on reserved select");
endmodule

// >>> verification/sgr_far_model.sv
// Purpose: Far side model: receive clocks, lane link status, MAC control bits
// Assumes: Receive clocks run continuously, unrelated in phase to mclk
// Notes:   Status and MAC bits change only right after an mclk edge
`timescale 1ns/10ps
module sgr_far_model #(
    parameter int HALF0 = 83,
    parameter int HALF1 = 211
) (
    // Clock
    input  wire logic       mclk,
    // Far side levels
    output logic [1:0]      recovered_receive_clock,
    output logic [6:0]      lane0_link_status,
    output logic [6:0]      lane1_link_status,
    output logic [3:0]      mac_ctrl
);
    logic rx0 = 1'b0;
    logic rx1 = 1'b0;

    assign recovered_receive_clock = {rx1, rx0};

    always #(HALF0) rx0 = ~rx0;
    always #(HALF1) rx1 = ~rx1;

    initial
    begin
        lane0_link_status = 7'h00;
        lane1_link_status = 7'h00;
        mac_ctrl = 4'h0;
    end

    task automatic set_link(input logic [6:0] l0, input logic [6:0] l1, input logic [3:0] m);
        @(posedge mclk);
        lane0_link_status <= l0;
        lane1_link_status <= l1;
        mac_ctrl <= m;
    endtask
endmodule

// >>> verification/tb.sv
// Purpose: Self-checking bench for the glue registers
// Assumes: Far side model supplies receive clocks and link status
// Notes:   Toggle gaps allow one mclk of phase slack
`timescale 1ns/10ps
`include "sgr_map.svh"
module tb;
    localparam int H0 = 83;
    localparam int H1 = 211;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_writedata = 32'h0000_0000;
    wire  [31:0] avs_readdata;
    wire         avs_waitrequest;
    wire  [1:0]  rx_clk;
    wire  [6:0]  lane0;
    wire  [6:0]  lane1;
    wire  [3:0]  mac;
    wire  [5:0]  outs;
    wire         sync_out;
    int          miscompares = 0;
    int          compares = 0;
    logic [31:0] rd;
    int          n;

    always #10 mclk = ~mclk;

    sgr_far_model #(.HALF0(H0), .HALF1(H1)) far (.mclk(mclk), .recovered_receive_clock(rx_clk),
        .lane0_link_status(lane0), .lane1_link_status(lane1), .mac_ctrl(mac));

    // Arbitrary ident values, every field non-zero
    sgr_glue_regs #(.IDENT(16'hC3A1), .RTL_VER(5'h15), .MAJ_VER(3'h6), .MINOR_VER(8'h9E))
        dut (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .recovered_receive_clock(rx_clk),
        .lane0_link_status(lane0), .lane1_link_status(lane1),
        .port1_mac_ctrl_tengig_en(mac[0]), .port1_mac_ctrl_gig_en(mac[1]),
        .port2_mac_ctrl_tengig_en(mac[2]), .port2_mac_ctrl_gig_en(mac[3]),
        .port1_tengig_enable(outs[0]), .port1_gig_enable(outs[1]), .port2_tengig_enable(outs[2]),
        .port2_gig_enable(outs[3]), .port1_tengig_mode(outs[4]), .port2_tengig_mode(outs[5]),
        .sync_toggle_output(sync_out));

    ////////////////////////////////////////////////////////////////////////////
    // Tasks
    task automatic conclude();
        if (miscompares == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
                       output logic [31:0] q);
        @(posedge mclk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= d;
        avs_byteenable <= be;
        do
            @(posedge mclk);
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF, rd);
    endtask

    task automatic rdc(input string name, input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000, 4'hF, rd);
        check(name, rd, e);
    endtask

    task automatic gap(output int g);
        logic s;
        int   k;
        s = sync_out;
        k = 0;
        while (sync_out === s && k < 300)
        begin
            @(posedge mclk);
            k++;
        end
        s = sync_out;
        g = 0;
        while (sync_out === s && g < 300)
        begin
            @(posedge mclk);
            g++;
        end
    endtask

    task automatic tgl(input string name, input int c, input int half);
        int lo;
        lo = c * 2 * half / 20;
        gap(n);
        check(name, {31'h0, n >= lo && n <= lo + 1}, 32'h0000_0001);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog
    initial
    begin
        #400000;
        miscompares++;
        conclude();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Tests
    initial
    begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        check("outputs after reset", {25'h0, sync_out, outs}, 32'h0000_0000);
        rdc("ident", `SGR_OFS_IDVER, 32'hC3A1_AE9E);
        rdc("count reset", `SGR_OFS_COUNT, 32'h0000_0000);
        rdc("select reset", `SGR_OFS_SEL, 32'h0000_0000);
        rdc("control reset", `SGR_OFS_CTRL, 32'h0000_0000);
        wr(4'h0, 32'hFFFF_FFFF);
        rdc("ident read only", 4'h0, 32'hC3A1_AE9E);
        wr(4'h4, 32'hA5A5_0F0F);
        wr(4'h6, 32'h1111_1111);
        rdc("count", 4'h4, 32'hA5A5_0F0F);
        rdc("unmapped", 4'h6, 32'h0000_0000);
        wr(4'h8, 32'hFFFF_FFFF);
        rdc("select", 4'h8, 32'h0000_0003);
        wr(4'hC, 32'hFFFF_FFFF);
        rdc("control", 4'hC, 32'h0000_0003);
        wr(4'h4, 32'h0000_0000);
        bus(1'b1, 4'h4, 32'h1234_5678, 4'h2, rd);
        rdc("count byte lane", 4'h4, 32'h0000_5600);
        wr(4'h4, 32'h0000_0000);
        wr(4'hC, 32'h0000_0000);
        for (int i = 0; i < 16; i++)
        begin
            far.set_link(7'h7F, 7'h7F, i[3:0]);
            repeat (2) @(posedge mclk);
            check("mac enables", {26'h0, outs}, {28'h0, i[3:0]});
        end
        wr(4'hC, 32'h0003_0300);
        for (int i = 0; i < 16; i++)
        begin
            far.set_link({2'h0, i[3:2], 3'h7}, {i[3:2], i[1:0], 3'h2}, 4'hF);
            repeat (4) @(posedge mclk);
            check("lane sources", {26'h0, outs}, {26'h0, i[1:0] == 2'h3, i[3:2] == 2'h3, i[3:2] == 2'h3,
                i[1:0] == 2'h3, i[3:2] == 2'h3, i[1:0] == 2'h3});
        end
        far.set_link(7'h7F, 7'h7F, 4'h0);
        wr(4'hC, 32'h0002_0001);
        repeat (2) @(posedge mclk);
        check("mixed port2 lane", {26'h0, outs}, 32'h0000_001C);
        wr(4'hC, 32'h0001_0002);
        repeat (2) @(posedge mclk);
        check("mixed port1 lane", {26'h0, outs}, 32'h0000_0023);
        wr(4'hC, 32'h0000_0000);
        bus(1'b1, 4'hC, 32'h0003_0301, 4'h1, rd);
        repeat (2) @(posedge mclk);
        check("control byte lane", {26'h0, outs}, 32'h0000_0010);
        rdc("control byte lane read", 4'hC, 32'h0000_0001);
        wr(4'hC, 32'h0000_0000);
        wr(4'h8, 32'h0000_0000);
        repeat (60) @(posedge mclk);
        check("zero count idle", {31'h0, sync_out}, 32'h0000_0000);
        wr(4'h4, 32'h0000_0003);
        tgl("rx0 toggle gap", 3, H0);
        wr(4'h4, 32'h0000_0000);
        wr(4'h8, 32'h0000_0001);
        wr(4'h4, 32'h0000_0002);
        tgl("rx1 toggle gap", 2, H1);
        wr(4'h8, 32'h0000_0002);
        gap(n);
        check("reserved select hold", n, 300);
        wr(4'h4, 32'h0000_0000);
        repeat (3) @(posedge mclk);
        check("zero count low", {31'h0, sync_out}, 32'h0000_0000);
        conclude();
    end
endmodule
